// ---- src/rps_pkg.sv ----
// Purpose: constants for the power-up supervisor and user scratch bytes
// Assumes: 20 MHz reference clock, byte-wide register port
// Notes:   offsets are byte addresses on the byte-wide register port
package rps_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] INT_CTRL_ADDR   = 8'h01;
	localparam logic [7:0] STATUS_ADDR     = 8'h03;
	localparam logic [7:0] TEMP_ADDR       = 8'h20;
	localparam logic [7:0] NV_CTRL_ADDR    = 8'h30;
	localparam logic [7:0] SCRATCH_FIRST   = 8'h38;
	localparam logic [7:0] SCRATCH_LAST    = 8'h3f;
	localparam int         SCRATCH_BYTES   = 8;

	// ****************************************
	// field positions
	// ****************************************
	localparam int STATUS_PON_BIT   = 5;
	localparam int STATUS_CRIT_BIT  = 3;
	localparam int STATUS_WARN_BIT  = 2;
	localparam int INT_CRIT_EN_BIT  = 3;
	localparam int INT_WARN_EN_BIT  = 2;
	localparam int NV_THERM_EN_BIT  = 1;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] INT_CTRL_RST    = 8'h00;
	localparam logic [7:0] NV_CTRL_RST     = 8'h00;
	localparam logic [7:0] TEMP_RST        = 8'h00;
	localparam logic [7:0] SCRATCH_RST     = 8'h00;
	localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

	// ****************************************
	// timing
	// ****************************************
	localparam longint CLK_HZ          = 20_000_000;
	localparam longint SLOW_SCAN_MS    = 1000;
	localparam longint FAST_SCAN_US    = 1000;
	localparam longint SLOW_SCAN_CYC   = CLK_HZ / 1000 * SLOW_SCAN_MS;
	localparam longint FAST_SCAN_CYC   = CLK_HZ / 1_000_000 * FAST_SCAN_US;

	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [5:0] {
		ST_RESET = 6'b000001,
		ST_OSC   = 6'b000010,
		ST_FAST  = 6'b000100,
		ST_NV    = 6'b001000,
		ST_TEMP  = 6'b010000,
		ST_RUN   = 6'b100000
	} rps_state_e;
endpackage

// ---- src/rps_supervisor.sv ----
// Purpose: power-up sequencing, low-supply supervision, user scratch bytes
// Assumes: all inputs synchronous to ref_clk_i; comparator levels are analog results
// Notes:   the register port is the byte interface behind the two-wire host front end
//
// Operation
// - eight scratch bytes at 38h through 3Fh
// - held in reset, then all registers reset
// - power-on flag set after reset, host clears
// - oscillator present starts fast supply scanning
// - above critical threshold ends fast scan, enables storage
// - load configuration, force both low flags zero
// - thermometer enabled: measure, then compute compensation
// - above critical: clear flags, scan once per second
// - flags still set keep temperature frozen
// - periodic compare sets matching low-supply flag
// - low supply disables functions needing voltage
// - below warning: hold reading, compensation continues
// - interrupt on low flag only when enabled
// - backup supply disables host interface, clock output
`timescale 1ns/10ps
module rps_supervisor
	import rps_pkg::*;
#(
	parameter longint SLOW_CYC = rps_pkg::SLOW_SCAN_CYC,
	parameter longint FAST_CYC = rps_pkg::FAST_SCAN_CYC
) (
	// clock and power-up reset
	input  wire logic       ref_clk_i,
	input  wire logic       resetn_i,
	// analog status
	input  wire logic       osc_ready_i,
	input  wire logic       above_warn_i,
	input  wire logic       above_crit_i,
	input  wire logic       backup_supply_input_i,
	// nonvolatile configuration
	input  wire logic [7:0] nv_data_i,
	input  wire logic       nv_valid_i,
	output logic            nv_rd_en_o,
	// thermometer and compensation
	input  wire logic [7:0] temp_meas_i,
	input  wire logic       temp_valid_i,
	output logic            temp_req_o,
	output logic            comp_start_o,
	output logic            therm_en_o,
	output logic            fcu_en_o,
	// host register port
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic [7:0]      reg_rdata_o,
	// outputs
	output logic            intf_en_o,
	output logic            clock_output_pin_en_o,
	output logic            int_o,
	output logic            fast_scan_o
);
	import rps_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	rps_state_e  state;
	logic [31:0] scan_cnt;
	logic        scan_tick;
	logic        power_on_flag;
	logic        low_supply_warn_flag;
	logic        low_supply_critical_flag;
	logic [7:0]  int_ctrl;
	logic [7:0]  nv_ctrl;
	logic [7:0]  temp_reg;
	logic [7:0]  scratch [SCRATCH_BYTES];
	logic        pon_armed;
	logic        host_wr;
	logic        host_rd;
	logic        therm_ok;
	logic        boot_meas;
	logic [7:0]  next_rdata;

	// decodes the scratch window; used for reads only, writes decode each byte address
	function automatic logic in_scratch(input logic [7:0] a);
		return (a >= SCRATCH_FIRST) && (a <= SCRATCH_LAST);
	endfunction

	// host strobes are ignored while the interface is switched off
	assign host_wr = reg_wr_i & ~backup_supply_input_i;
	assign host_rd = reg_rd_i & ~backup_supply_input_i;

	// thermometer may run only with both flags clear and enough supply
	assign therm_ok = nv_ctrl[NV_THERM_EN_BIT] & above_warn_i
		& ~low_supply_warn_flag & ~low_supply_critical_flag;

	// the stored byte reaches nv_ctrl on the same edge that asks for the first
	// reading, so this decision looks at the incoming byte and not at nv_ctrl;
	// the flags are forced clear on that edge, so they cannot block it, and
	// without this the sequencer would wait in its measuring state for nothing
	assign boot_meas = state == ST_NV && nv_valid_i && nv_data_i[NV_THERM_EN_BIT]
		&& above_warn_i;

	// ****************************************
	// scan timer
	// ****************************************
	// one tick per scan period; fast period until the sequencer leaves fast mode
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scan_cnt  <= 32'h0000_0000;
			scan_tick <= 1'b0;
		end else if (state == ST_RESET || state == ST_OSC) begin
			scan_cnt  <= 32'h0000_0000;
			scan_tick <= 1'b0;
		end else if (scan_cnt >= 32'((state == ST_FAST) ? FAST_CYC - 1 : SLOW_CYC - 1)) begin
			scan_cnt  <= 32'h0000_0000;
			scan_tick <= 1'b1;
		end else begin
			scan_cnt  <= scan_cnt + 32'h0000_0001;
			scan_tick <= 1'b0;
		end
	end

	// ****************************************
	// power-up sequencer
	// ****************************************
	// the asynchronous reset stands for the supply-threshold reset
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_RESET;
		end else begin
			unique case (state)
				ST_RESET: begin
					state <= ST_OSC;
				end
				ST_OSC: begin
					if (osc_ready_i) begin
						state <= ST_FAST;
					end
				end
				ST_FAST: begin
					if (scan_tick && above_crit_i) begin
						state <= ST_NV;
					end
				end
				ST_NV: begin
					if (nv_valid_i) begin
						state <= nv_data_i[NV_THERM_EN_BIT] ? ST_TEMP : ST_RUN;
					end
				end
				ST_TEMP: begin
					// waits for the reading asked for on entry; a far side that never
					// answers holds the sequencer here, a lost supply margin lets it go on
					if (temp_valid_i || !therm_ok) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// ****************************************
	// power-on flag
	// ****************************************
	// set once after the reset values are in place; host write of zero clears it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			power_on_flag <= 1'b0;
			pon_armed     <= 1'b1;
		end else if (pon_armed) begin
			power_on_flag <= 1'b1;
			pon_armed     <= 1'b0;
		end else if (host_wr && reg_addr_i == STATUS_ADDR
			&& !reg_wdata_i[STATUS_PON_BIT]) begin
			power_on_flag <= 1'b0;
		end
	end

	// ****************************************
	// low-supply flags
	// ****************************************
	// set on a tick when below a threshold; a set in the cycle of a host clearing write wins
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			low_supply_warn_flag     <= 1'b0;
			low_supply_critical_flag <= 1'b0;
		end else if (state == ST_FAST && scan_tick && above_crit_i) begin
			low_supply_warn_flag     <= 1'b0;
			low_supply_critical_flag <= 1'b0;
		// the forced clear on the configuration load also drops a tick's set in
		// that same cycle; a supply still low is caught again on the next tick
		end else if (state == ST_NV && nv_valid_i) begin
			low_supply_warn_flag     <= 1'b0;
			low_supply_critical_flag <= 1'b0;
		end else begin
			if (scan_tick && !above_warn_i) begin
				low_supply_warn_flag <= 1'b1;
			end else if (host_wr && reg_addr_i == STATUS_ADDR
				&& !reg_wdata_i[STATUS_WARN_BIT]) begin
				low_supply_warn_flag <= 1'b0;
			end
			if (scan_tick && !above_crit_i) begin
				low_supply_critical_flag <= 1'b1;
			end else if (host_wr && reg_addr_i == STATUS_ADDR
				&& !reg_wdata_i[STATUS_CRIT_BIT]) begin
				low_supply_critical_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// nonvolatile control is loaded at power-up and may be rewritten by the host
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nv_ctrl  <= NV_CTRL_RST;
			int_ctrl <= INT_CTRL_RST;
		end else begin
			if (state == ST_NV && nv_valid_i) begin
				nv_ctrl <= nv_data_i;
			end else if (host_wr && reg_addr_i == NV_CTRL_ADDR) begin
				nv_ctrl <= reg_wdata_i;
			end
			if (host_wr && reg_addr_i == INT_CTRL_ADDR) begin
				int_ctrl <= reg_wdata_i;
			end
		end
	end

	// ****************************************
	// temperature register
	// ****************************************
	// stays at its reset value of zero until a measurement is allowed;
	// while the thermometer is off the last reading is simply kept
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			temp_reg <= TEMP_RST;
		end else if (temp_valid_i && therm_ok && (state == ST_TEMP || state == ST_RUN)) begin
			temp_reg <= temp_meas_i;
		end
	end

	// ****************************************
	// thermometer and compensation control
	// ****************************************
	// request one reading at power-up, then one per slow tick while allowed
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			temp_req_o   <= 1'b0;
			comp_start_o <= 1'b0;
		end else begin
			temp_req_o   <= boot_meas
				|| (therm_ok && state == ST_RUN && scan_tick);
			comp_start_o <= temp_valid_i && therm_ok
				&& (state == ST_TEMP || state == ST_RUN);
		end
	end

	// ****************************************
	// function enables
	// ****************************************
	// compensation keeps running on the held reading down to the critical level
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			therm_en_o            <= 1'b0;
			fcu_en_o              <= 1'b0;
			nv_rd_en_o            <= 1'b0;
			fast_scan_o           <= 1'b0;
			intf_en_o             <= 1'b0;
			clock_output_pin_en_o <= 1'b0;
		end else begin
			therm_en_o  <= therm_ok && (state == ST_TEMP || state == ST_RUN);
			fcu_en_o    <= above_crit_i && (state == ST_TEMP || state == ST_RUN);
			nv_rd_en_o  <= above_crit_i && state == ST_NV;
			fast_scan_o <= state == ST_FAST;
			intf_en_o             <= !backup_supply_input_i;
			clock_output_pin_en_o <= !backup_supply_input_i;
		end
	end

	// ****************************************
	// interrupt
	// ****************************************
	// a level that follows the flags, gated by the enables
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			int_o <= 1'b0;
		end else begin
			int_o <= (low_supply_warn_flag & int_ctrl[INT_WARN_EN_BIT])
				| (low_supply_critical_flag & int_ctrl[INT_CRIT_EN_BIT]);
		end
	end

	// ****************************************
	// user scratch bytes
	// ****************************************
	// one byte per address; no side effects on read or write
	// plain flops rather than a memory, so each byte keeps its own write decode
	generate
		for (genvar i = 0; i < SCRATCH_BYTES; i++) begin : g_scratch
			always_ff @(posedge ref_clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					scratch[i] <= SCRATCH_RST;
				end else if (host_wr && reg_addr_i == SCRATCH_FIRST + 8'(i)) begin
					scratch[i] <= reg_wdata_i;
				end
			end
		end
	endgenerate

	// ****************************************
	// read path
	// ****************************************
	// unmapped addresses read as zero
	// the address is decoded here and the byte captured on the strobe edge below
	always_comb begin
		next_rdata = UNMAPPED_DATA;
		if (in_scratch(reg_addr_i)) begin
			next_rdata = scratch[reg_addr_i[2:0]];
		end else if (reg_addr_i == STATUS_ADDR) begin
			next_rdata[STATUS_PON_BIT]  = power_on_flag;
			next_rdata[STATUS_CRIT_BIT] = low_supply_critical_flag;
			next_rdata[STATUS_WARN_BIT] = low_supply_warn_flag;
		end else if (reg_addr_i == INT_CTRL_ADDR) begin
			next_rdata = int_ctrl;
		end else if (reg_addr_i == NV_CTRL_ADDR) begin
			next_rdata = nv_ctrl;
		end else if (reg_addr_i == TEMP_ADDR) begin
			next_rdata = temp_reg;
		end
	end

	// read data is held until the next accepted read
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= UNMAPPED_DATA;
		end else if (host_rd) begin
			reg_rdata_o <= next_rdata;
		end
	end
endmodule

// ---- dv/rps_supervisor_properties.sv ----
// Purpose: port-level assertions for the power-up supervisor
// Assumes: bound to every rps_supervisor instance
// Notes:   flags are internal, so checks tie outputs to their input causes
`timescale 1ns/10ps
module rps_chk #(
	parameter longint SLOW_CYC = 1,
	parameter longint FAST_CYC = 1
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// watched ports
	input wire logic above_warn_i,
	input wire logic above_crit_i,
	input wire logic backup_supply_input_i,
	input wire logic temp_valid_i,
	input wire logic nv_rd_en_o,
	input wire logic temp_req_o,
	input wire logic comp_start_o,
	input wire logic therm_en_o,
	input wire logic fcu_en_o,
	input wire logic intf_en_o,
	input wire logic clock_output_pin_en_o,
	input wire logic fast_scan_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	// ****************************************
	// assertions
	// ****************************************
	a_iface_follow: assert property (1'b1 |=> intf_en_o == !$past(backup_supply_input_i))
		else $error("host interface enable does not follow backup state");
	a_clock_output_pin_off: assert property (backup_supply_input_i |=> !clock_output_pin_en_o)
		else $error("clock output enabled on backup supply");
	a_fcu_crit: assert property (!above_crit_i |=> !fcu_en_o)
		else $error("compensation enabled below critical level");
	a_therm_warn: assert property (!above_warn_i |=> !therm_en_o)
		else $error("thermometer enabled below warning level");
	a_nv_gate: assert property (!above_crit_i |=> !nv_rd_en_o)
		else $error("storage read allowed below critical level");
	a_fast_excl: assert property (fast_scan_o |-> !nv_rd_en_o)
		else $error("storage read allowed during fast scan");
	a_req_pulse: assert property (temp_req_o |=> !temp_req_o)
		else $error("measurement request longer than one cycle");
	a_comp_cause: assert property (comp_start_o |-> $past(temp_valid_i))
		else $error("compensation start without a measurement");

	// main scenarios reached
	c_fast: cover property ($rose(fast_scan_o));
	c_nv: cover property ($rose(nv_rd_en_o));
	c_comp: cover property (comp_start_o);
endmodule

bind rps_supervisor rps_chk #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_rps_chk (
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .above_warn_i(above_warn_i),
	.above_crit_i(above_crit_i), .backup_supply_input_i(backup_supply_input_i),
	.temp_valid_i(temp_valid_i), .nv_rd_en_o(nv_rd_en_o), .temp_req_o(temp_req_o),
	.comp_start_o(comp_start_o), .therm_en_o(therm_en_o), .fcu_en_o(fcu_en_o),
	.intf_en_o(intf_en_o), .clock_output_pin_en_o(clock_output_pin_en_o),
	.fast_scan_o(fast_scan_o));

// ---- dv/rps_far_model.sv ----
// Purpose: storage and thermometer responder beside the supervisor
// Assumes: answers are one-cycle pulses DLY cycles after the request
// Notes:   data lines toggle when not valid, so stale values never pass
`timescale 1ns/10ps
module rps_far_model #(
	parameter int         DLY     = 3,
	parameter logic [7:0] NV_BYTE = 8'h02,
	parameter logic [7:0] T_VAL   = 8'h19
) (
	// clock
	input  wire logic       clk_i,
	// requests
	input  wire logic       nv_rd_en_i,
	input  wire logic       temp_req_i,
	// answers
	output logic [7:0]      nv_data_o,
	output logic            nv_valid_o,
	output logic [7:0]      temp_meas_o,
	output logic            temp_valid_o
);
	logic nv_q = 0;
	int   nv_cnt = 0;
	int   t_cnt = 0;

	initial begin
		nv_data_o = 8'h00;
		nv_valid_o = 0;
		temp_meas_o = 8'h00;
		temp_valid_o = 0;
	end

	// ****************************************
	// responders
	// ****************************************
	// a larger DLY models a slow part; storage reads start only on a fresh enable, measurements on every request
	always @(posedge clk_i) begin
		nv_q <= nv_rd_en_i;
		nv_valid_o <= (nv_cnt == 1);
		nv_data_o <= (nv_cnt == 1) ? NV_BYTE : ~nv_data_o;
		if (nv_rd_en_i && !nv_q)
			nv_cnt <= DLY;
		else if (nv_cnt > 0)
			nv_cnt <= nv_cnt - 1;
		temp_valid_o <= (t_cnt == 1);
		temp_meas_o <= (t_cnt == 1) ? T_VAL : ~temp_meas_o;
		if (temp_req_i)
			t_cnt <= DLY;
		else if (t_cnt > 0)
			t_cnt <= t_cnt - 1;
	end
endmodule

// ---- dv/testbench.sv ----
// Purpose: directed bench for the power-up supervisor
// Assumes: scan counts shortened to 20 and 200 cycles
// Notes:   register traffic goes through wr and rd tasks at falling edges
`timescale 1ns/10ps
module testbench;
	import rps_pkg::*;
	localparam longint FAST = 20;
	localparam longint SLOW = 200;
	logic       ref_clk_i = 0, resetn_i = 0, osc_ready_i = 0, above_warn_i = 0;
	logic       above_crit_i = 0, backup_supply_input_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, nv_data_i, temp_meas_i, reg_rdata_o;
	logic       nv_valid_i, temp_valid_i, nv_rd_en_o, temp_req_o, comp_start_o;
	logic       therm_en_o, fcu_en_o, intf_en_o, clock_output_pin_en_o, int_o, fast_scan_o;
	int         err_total = 0, n_compared = 0, i;

	rps_supervisor #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_rps_supervisor (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .osc_ready_i(osc_ready_i),
		.above_warn_i(above_warn_i), .above_crit_i(above_crit_i),
		.backup_supply_input_i(backup_supply_input_i), .nv_data_i(nv_data_i),
		.nv_valid_i(nv_valid_i), .nv_rd_en_o(nv_rd_en_o), .temp_meas_i(temp_meas_i),
		.temp_valid_i(temp_valid_i), .temp_req_o(temp_req_o), .comp_start_o(comp_start_o),
		.therm_en_o(therm_en_o), .fcu_en_o(fcu_en_o), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .intf_en_o(intf_en_o),
		.clock_output_pin_en_o(clock_output_pin_en_o), .int_o(int_o),
		.fast_scan_o(fast_scan_o));
	rps_far_model u_rps_far_model (.clk_i(ref_clk_i), .nv_rd_en_i(nv_rd_en_o),
		.temp_req_i(temp_req_o), .nv_data_o(nv_data_i), .nv_valid_o(nv_valid_i),
		.temp_meas_o(temp_meas_i), .temp_valid_o(temp_valid_i));

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_wr_i = 1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge ref_clk_i);
		reg_wr_i = 0;
	endtask

	// data is registered on the strobe edge, so it is settled half a cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		reg_rd_i = 1;
		reg_addr_i = a;
		@(negedge ref_clk_i);
		reg_rd_i = 0;
		chk(reg_rdata_o, exp);
	endtask

	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always #25 ref_clk_i = ~ref_clk_i;

	// watchdog well beyond the roughly 500 cycles the tests need
	initial begin
		repeat (4000) @(posedge ref_clk_i);
		err_total++;
		conclude();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (6) @(negedge ref_clk_i);
		resetn_i = 1;
		rd(STATUS_ADDR, 8'h20);
		rd(SCRATCH_LAST, SCRATCH_RST);
		osc_ready_i = 1;
		for (i = 0; i < 10 && fast_scan_o !== 1'b1; i++) @(negedge ref_clk_i);
		chk({7'h0, fast_scan_o}, 8'h01);
		repeat (FAST + 5) @(negedge ref_clk_i);
		rd(STATUS_ADDR, 8'h2c);
		chk({7'h0, fast_scan_o}, 8'h01);
		above_warn_i = 1;
		above_crit_i = 1;
		for (i = 0; i < FAST + 5 && nv_rd_en_o !== 1'b1; i++) @(negedge ref_clk_i);
		chk({7'h0, nv_rd_en_o}, 8'h01);
		chk({7'h0, fast_scan_o}, 8'h00);
		repeat (20) @(negedge ref_clk_i);
		rd(STATUS_ADDR, 8'h20);
		rd(NV_CTRL_ADDR, 8'h02);
		rd(TEMP_ADDR, 8'h19);
		chk({6'h0, therm_en_o, fcu_en_o}, 8'h03);
		$display("power-up test done");
		wr(INT_CTRL_ADDR, 8'h0c);
		above_warn_i = 0;
		for (i = 0; i < SLOW + 5 && int_o !== 1'b1; i++) @(negedge ref_clk_i);
		chk({7'h0, int_o}, 8'h01);
		chk({7'h0, therm_en_o}, 8'h00);
		chk({7'h0, fcu_en_o}, 8'h01);
		rd(STATUS_ADDR, 8'h24);
		rd(TEMP_ADDR, 8'h19);
		above_warn_i = 1;
		wr(STATUS_ADDR, 8'h20);
		@(negedge ref_clk_i);
		chk({7'h0, int_o}, 8'h00);
		wr(INT_CTRL_ADDR, 8'h00);
		above_warn_i = 0;
		repeat (SLOW + 5) @(negedge ref_clk_i);
		rd(STATUS_ADDR, 8'h24);
		chk({7'h0, int_o}, 8'h00);
		above_warn_i = 1;
		wr(STATUS_ADDR, 8'h00);
		rd(STATUS_ADDR, 8'h00);
		$display("low-supply test done");
		for (i = 0; i < SCRATCH_BYTES; i++) wr(SCRATCH_FIRST + i[7:0], 8'ha0 + i[7:0]);
		for (i = 0; i < SCRATCH_BYTES; i++) rd(SCRATCH_FIRST + i[7:0], 8'ha0 + i[7:0]);
		rd(8'h40, UNMAPPED_DATA);
		backup_supply_input_i = 1;
		wr(SCRATCH_FIRST, 8'h5a);
		chk({6'h0, intf_en_o, clock_output_pin_en_o}, 8'h00);
		backup_supply_input_i = 0;
		rd(SCRATCH_FIRST, 8'ha0);
		$display("scratch and backup test done");
		conclude();
	end
endmodule
